// ### rtl/pidpc_pkg.sv
package pidpc_pkg;
   // Timing of the control sample.
   localparam int CLK_PERIOD_NS = 10;
   localparam int SAMPLE_PERIOD_NS = 1_000_000;
   localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SAMP_PER_10MS = 10_000_000 / SAMPLE_PERIOD_NS;
   localparam int SAMP_PER_100MS = 100_000_000 / SAMPLE_PERIOD_NS;

   // Register word indices; byte address is four times the index.
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_KEYPAD = 6'h01;
   localparam logic [5:0] REG_SETPT = 6'h02;
   localparam logic [5:0] REG_FBGAIN = 6'h03;
   localparam logic [5:0] REG_KP = 6'h04;
   localparam logic [5:0] REG_TI = 6'h05;
   localparam logic [5:0] REG_TD = 6'h06;
   localparam logic [5:0] REG_BIAS = 6'h07;
   localparam logic [5:0] REG_FILT = 6'h08;
   localparam logic [5:0] REG_ILIM = 6'h09;
   localparam logic [5:0] REG_OLIM = 6'h0a;
   localparam logic [5:0] REG_OGAIN = 6'h0b;
   localparam logic [5:0] REG_RAMP = 6'h0c;
   localparam logic [5:0] REG_DISP = 6'h0d;
   localparam logic [5:0] REG_STATUS = 6'h0e;
   localparam logic [5:0] REG_OUT = 6'h0f;
   localparam logic [5:0] REG_FB = 6'h10;
   localparam int NUM_RW = 14;

   // Control register fields.
   localparam int CTRL_EN = 0;
   localparam int CTRL_NEG = 1;
   localparam int CTRL_DFB = 2;
   localparam int CTRL_ADD = 3;
   localparam int CTRL_REV = 4;
   localparam int CTRL_TSRC = 8;
   localparam int CTRL_FSRC = 12;
   // Display register fields.
   localparam int DISP_LED = 0;
   localparam int DISP_DEC = 4;
   localparam int DISP_FBMAX = 16;

   // Source codes.
   localparam logic [2:0] SRC_KEYPAD = 3'h0;
   localparam logic [2:0] SRC_AI1 = 3'h1;
   localparam logic [2:0] SRC_AI2 = 3'h2;
   localparam logic [2:0] SRC_SETPT = 3'h4;
   localparam logic [2:0] SRC_DIFF = 3'h4;

   // Scaling: percentages in 0.01 % steps, integral state 100x finer.
   localparam int FULL_SCALE = 10000;
   localparam int FB_CEIL = 20000;
   localparam int INT_SCALE = 100;
   localparam int FB_MAX_DISP = 1000;
   localparam logic [1:0] DEC_ONE = 2'h1;

   localparam logic [31:0] RST_VALS [NUM_RW] = '{
      32'h0000_2101, 32'h0000_0000, 32'h0000_0000, 32'h0000_0064,
      32'h0000_0064, 32'h0000_000a, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0000, 32'h0000_03e8, 32'h0000_2710, 32'h0000_000a,
      32'h0000_0000, 32'h0000_0001};
endpackage

// ### rtl/pidpc_top.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pidpc_top
#(
   parameter int SAMPLE_CYC = pidpc_pkg::SAMPLE_CYCLES
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Avalon-MM register slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Process inputs
   input wire logic [15:0] analog_input_one,
   input wire logic [15:0] analog_input_two,
   input wire logic [15:0] main_freq_cmd,
   input wire logic run,
   input wire logic soft_setpoint_ramp_off,
   // Frequency reference path and setting error
   output logic [15:0] freq_ref,
   output logic reverse_dir,
   output logic regulator_setting_error
);
   import pidpc_pkg::*;

   typedef logic signed [31:0] pidpc_val_t;

   function automatic logic [31:0] pidpc_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[8*i +: 8] = wd[8*i +: 8];
      return r;
   endfunction

   function automatic pidpc_val_t pidpc_ext(input logic [15:0] v);
      return pidpc_val_t'({16'h0000, v});
   endfunction

   function automatic pidpc_val_t pidpc_clamp(input pidpc_val_t v,
      input pidpc_val_t lo, input pidpc_val_t hi);
      if (v > hi)
         return hi;
      if (v < lo)
         return lo;
      return v;
   endfunction

   // Input synchronisers: a word is taken once two late stages agree.
   logic [15:0] pin_w [3];
   logic [15:0] win_s1 [3];
   logic [15:0] win_s2 [3];
   logic [15:0] win_s3 [3];
   logic [15:0] win_q [3];
   logic [1:0] bit_s1, bit_s2, bit_s3, bit_q;

   assign pin_w[0] = analog_input_one;
   assign pin_w[1] = analog_input_two;
   assign pin_w[2] = main_freq_cmd;

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_word
         always_ff @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
            begin
               win_s1[g] <= 16'h0000;
               win_s2[g] <= 16'h0000;
               win_s3[g] <= 16'h0000;
               win_q[g] <= 16'h0000;
            end
            else
            begin
               win_s1[g] <= pin_w[g];
               win_s2[g] <= win_s1[g];
               win_s3[g] <= win_s2[g];
               if (win_s2[g] == win_s3[g])
                  win_q[g] <= win_s3[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bit_s1 <= 2'h0;
         bit_s2 <= 2'h0;
         bit_s3 <= 2'h0;
         bit_q <= 2'h0;
      end
      else
      begin
         bit_s1 <= {run, soft_setpoint_ramp_off};
         bit_s2 <= bit_s1;
         bit_s3 <= bit_s2;
         for (int i = 0; i < 2; i++)
            if (bit_s2[i] == bit_s3[i])
               bit_q[i] <= bit_s3[i];
      end
   end

   logic run_s, ramp_off_s, run_d1_q, run_start;
   assign run_s = bit_q[1];
   assign ramp_off_s = bit_q[0];
   assign run_start = run_s & ~run_d1_q;

   // Register file and bus slave; one wait state per access.
   logic [31:0] reg_q [NUM_RW];
   logic [31:0] avs_readdata_q, rd_mux;
   logic avs_waitrequest_q, bus_wr;
   logic [5:0] idx;
   logic [15:0] freq_ref_q;
   logic reverse_q, set_err_q;
   pidpc_val_t fb_scaled;

   assign idx = avs_address[7:2];
   assign bus_wr = avs_write & ~avs_waitrequest_q;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (idx < 6'(NUM_RW))
         rd_mux = reg_q[idx[3:0]];
      else if (idx == REG_STATUS)
         rd_mux = {29'h0000_0000, run_s, reverse_q, set_err_q};
      else if (idx == REG_OUT)
         rd_mux = {16'h0000, freq_ref_q};
      else if (idx == REG_FB)
         rd_mux = fb_scaled;
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         avs_waitrequest_q <= 1'b1;
         avs_readdata_q <= 32'h0000_0000;
      end
      else
      begin
         avs_waitrequest_q <= ~((avs_read | avs_write) & avs_waitrequest_q);
         if (avs_read & avs_waitrequest_q)
            avs_readdata_q <= rd_mux;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < NUM_RW; i++)
            reg_q[i] <= RST_VALS[i];
      end
      else if (bus_wr && idx < 6'(NUM_RW))
         reg_q[idx[3:0]] <= pidpc_merge(reg_q[idx[3:0]], avs_writedata,
            avs_byteenable);
   end

   // Setting fields.
   logic [31:0] ctrl, disp;
   logic en, neg, dfb, add_cmd, rev_ok;
   logic [2:0] tsrc, fsrc;
   assign ctrl = reg_q[REG_CTRL[3:0]];
   assign disp = reg_q[REG_DISP[3:0]];
   assign en = ctrl[CTRL_EN];
   assign neg = ctrl[CTRL_NEG];
   assign dfb = ctrl[CTRL_DFB];
   assign add_cmd = ctrl[CTRL_ADD];
   assign rev_ok = ctrl[CTRL_REV];
   assign tsrc = ctrl[CTRL_TSRC +: 3];
   assign fsrc = ctrl[CTRL_FSRC +: 3];

   pidpc_val_t ai1, ai2, cmd, kp, ti, td, filt, ilim, olim, ogain, bias;
   pidpc_val_t ramp_t, fbgain;
   assign ai1 = pidpc_ext(win_q[0]);
   assign ai2 = pidpc_ext(win_q[1]);
   assign cmd = pidpc_ext(win_q[2]);
   assign fbgain = pidpc_ext(reg_q[REG_FBGAIN[3:0]][15:0]);
   assign kp = pidpc_ext(reg_q[REG_KP[3:0]][15:0]);
   assign ti = pidpc_ext(reg_q[REG_TI[3:0]][15:0]);
   assign td = pidpc_ext(reg_q[REG_TD[3:0]][15:0]);
   assign filt = pidpc_ext(reg_q[REG_FILT[3:0]][15:0]);
   assign ilim = pidpc_ext(reg_q[REG_ILIM[3:0]][15:0]);
   assign olim = pidpc_ext(reg_q[REG_OLIM[3:0]][15:0]);
   assign ogain = pidpc_ext(reg_q[REG_OGAIN[3:0]][15:0]);
   assign ramp_t = pidpc_ext({8'h00, reg_q[REG_RAMP[3:0]][7:0]});
   assign bias = pidpc_val_t'($signed(reg_q[REG_BIAS[3:0]][15:0]));

   // Control sample tick.
   logic [31:0] cnt_q;
   logic tick_q, clr;
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= (cnt_q == 32'(SAMPLE_CYC - 1));
         cnt_q <= (cnt_q == 32'(SAMPLE_CYC - 1)) ? 32'h0000_0000 :
            cnt_q + 32'h0000_0001;
      end
   end

   assign clr = ~en | run_start;

   pidpc_val_t tgt_raw, fb_raw, err, p_term, integ_q, integ_d, dsrc;
   pidpc_val_t dprev_q, d_term, sum, lim, filt_q, filt_d, comp, ramp_q;
   pidpc_val_t ramp_d, step, mag;
   logic [15:0] freq_d;

   always_comb
   begin
      case (tsrc)
         SRC_KEYPAD: tgt_raw = pidpc_ext(reg_q[REG_KEYPAD[3:0]][15:0]);
         SRC_AI1: tgt_raw = ai1;
         SRC_AI2: tgt_raw = ai2;
         SRC_SETPT: tgt_raw = pidpc_ext(reg_q[REG_SETPT[3:0]][15:0]) * 10;
         default: tgt_raw = 0;
      endcase
      tgt_raw = pidpc_clamp(tgt_raw, 0, FULL_SCALE);
      case (fsrc)
         SRC_AI1: fb_raw = ai1;
         SRC_AI2: fb_raw = ai2;
         SRC_DIFF: fb_raw = pidpc_clamp(ai1 - ai2, 0, FULL_SCALE * 8);
         default: fb_raw = 0;
      endcase
      fb_scaled = pidpc_clamp(fb_raw * fbgain / 100, 0, FB_CEIL);
      err = ramp_q - fb_scaled;
      p_term = err * kp / 100;
      integ_d = integ_q;
      if (ti != 0)
         integ_d = integ_q + (err * INT_SCALE) / (ti * SAMP_PER_100MS);
      integ_d = pidpc_clamp(integ_d, -(ilim * 10 * INT_SCALE),
         ilim * 10 * INT_SCALE);
      dsrc = dfb ? -fb_scaled : err;
      d_term = (dsrc - dprev_q) * td * SAMP_PER_10MS;
      sum = p_term + integ_d / INT_SCALE + d_term;
      if (neg)
         sum = -sum;
      lim = pidpc_clamp(sum, -olim, olim);
      filt_d = filt_q + (lim - filt_q) / (filt * SAMP_PER_10MS + 1);
      comp = (filt_d + bias * 100) * ogain / 10;
      if (add_cmd && run_s)
         comp = comp + cmd;
      if (!en)
         comp = cmd;
      if (comp < 0 && !rev_ok)
         comp = 0;
      mag = pidpc_clamp(comp < 0 ? -comp : comp, 0, 32'h0000_ffff);
      freq_d = mag[15:0];
      step = (ramp_t == 0) ? 0 : FULL_SCALE / (ramp_t * SAMP_PER_100MS);
      if (step == 0)
         step = 1;
      if (ramp_t == 0 || ramp_off_s)
         ramp_d = tgt_raw;
      else if (ramp_q < tgt_raw)
         ramp_d = (tgt_raw - ramp_q > step) ? ramp_q + step : tgt_raw;
      else
         ramp_d = (ramp_q - tgt_raw > step) ? ramp_q - step : tgt_raw;
   end

   // Regulator state updates once per sample; while clr is set, every clock clears integ_q and filt_q and loads dprev_q with dsrc.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         integ_q <= 0;
         filt_q <= 0;
         dprev_q <= 0;
      end
      else if (clr)
      begin
         integ_q <= 0;
         filt_q <= 0;
         dprev_q <= dsrc;
      end
      else if (tick_q)
      begin
         integ_q <= integ_d;
         filt_q <= filt_d;
         dprev_q <= dsrc;
      end
   end

   // The ramp restarts from zero so each run approaches its target.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         ramp_q <= 0;
      else if (run_start)
         ramp_q <= 0;
      else if (!en)
         ramp_q <= tgt_raw;
      else if (tick_q)
         ramp_q <= ramp_d;
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         freq_ref_q <= 16'h0000;
         reverse_q <= 1'b0;
         run_d1_q <= 1'b0;
      end
      else
      begin
         run_d1_q <= run_s;
         if (tick_q)
         begin
            freq_ref_q <= freq_d;
            reverse_q <= comp < 0;
         end
      end
   end

   logic same_src, disp_bad;
   assign same_src = (tsrc == fsrc) && (tsrc == SRC_AI1 || tsrc == SRC_AI2);
   assign disp_bad = ~disp[DISP_LED] &&
      !(disp[DISP_FBMAX +: 16] < 16'(FB_MAX_DISP) &&
        disp[DISP_DEC +: 2] == DEC_ONE);

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         set_err_q <= 1'b0;
      else
         set_err_q <= same_src | disp_bad;
   end

   assign avs_readdata = avs_readdata_q;
   assign avs_waitrequest = avs_waitrequest_q;
   assign freq_ref = freq_ref_q;
   assign reverse_dir = reverse_q;
   assign regulator_setting_error = set_err_q;

   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   property p_same_src;
      same_src |=> regulator_setting_error;
   endproperty
   a_same_src: assert property (p_same_src)
      else $error("same source did not raise setting error");

   property p_disp_err;
      disp_bad |=> regulator_setting_error;
   endproperty
   a_disp_err: assert property (p_disp_err)
      else $error("display limits did not raise setting error");

   property p_bypass;
      tick_q && !en |=> freq_ref == $past(win_q[2]);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass did not pass main command");

   property p_no_rev;
      tick_q && !rev_ok |=> !reverse_dir;
   endproperty
   a_no_rev: assert property (p_no_rev)
      else $error("reverse shown without permit");

   property p_integ_lim;
      tick_q && !clr |=> (integ_q <= $past(ilim) * 10 * INT_SCALE) &&
         (integ_q >= -($past(ilim) * 10 * INT_SCALE));
   endproperty
   a_integ_lim: assert property (p_integ_lim)
      else $error("integral outside its limit");

   property p_clear;
      run_start |=> integ_q == 0 && filt_q == 0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("run start did not clear states");

   property p_ramp_off;
      tick_q && en && !run_start && ramp_off_s |=> ramp_q == $past(tgt_raw);
   endproperty
   a_ramp_off: assert property (p_ramp_off)
      else $error("ramp not bypassed");

   // The filter only moves its state toward the limited sum, so a state that
   // starts inside the limit must stay there; a lowered limit may lag.
   property p_filt_lim;
      tick_q && !clr && filt_q <= olim && filt_q >= -olim |=>
         filt_q <= $past(olim) && filt_q >= -$past(olim);
   endproperty
   a_filt_lim: assert property (p_filt_lim)
      else $error("filtered output beyond output limit");

   property p_wait;
      (avs_read || avs_write) && avs_waitrequest |=>
         !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait)
      else $error("bus answer not one wait state");

   c_run_start: cover property (run_start ##[1:300] tick_q);
   c_reverse: cover property ($rose(reverse_dir));
   c_set_err: cover property ($rose(regulator_setting_error));
   c_ramp: cover property (tick_q && en && ramp_q != tgt_raw);
endmodule

// ### test/pidpc_plant.sv
`timescale 1ns/1ps
// Sensor model: each analog word follows its requested reading one clock
// late, as a converter that publishes a fresh sample every clock would.
module pidpc_plant
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Requested sensor readings
   input wire logic [15:0] one_set,
   input wire logic [15:0] two_set,
   // Sensor words toward the regulator
   output logic [15:0] analog_input_one,
   output logic [15:0] analog_input_two
);
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         analog_input_one <= 16'h0000;
         analog_input_two <= 16'h0000;
      end
      else
      begin
         analog_input_one <= one_set;
         analog_input_two <= two_set;
      end
   end
endmodule

// ### test/pid_process_controller_bench.sv
`timescale 1ns/1ps
module pid_process_controller_bench;
   import pidpc_pkg::*;
   // A short sample period keeps the run brief; the math is unchanged.
   localparam int SC = 50;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [15:0] analog_input_one;
   logic [15:0] analog_input_two;
   logic [15:0] one_set = 16'h0000;
   logic [15:0] two_set = 16'h0000;
   logic [15:0] main_freq_cmd = 16'h0000;
   logic run = 1'b0;
   logic soft_setpoint_ramp_off = 1'b0;
   logic [15:0] freq_ref;
   logic reverse_dir;
   logic regulator_setting_error;
   int n_mismatch = 0;
   int comparisons = 0;
   logic [31:0] rd;

   always #5 clock = ~clock;

   pidpc_top #(.SAMPLE_CYC(SC)) pidpc_top_i
   (
      .clock(clock),
      .arst_n(arst_n),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .analog_input_one(analog_input_one),
      .analog_input_two(analog_input_two),
      .main_freq_cmd(main_freq_cmd),
      .run(run),
      .soft_setpoint_ramp_off(soft_setpoint_ramp_off),
      .freq_ref(freq_ref),
      .reverse_dir(reverse_dir),
      .regulator_setting_error(regulator_setting_error)
   );

   pidpc_plant pidpc_plant_i
   (
      .clock(clock),
      .arst_n(arst_n),
      .one_set(one_set),
      .two_set(two_set),
      .analog_input_one(analog_input_one),
      .analog_input_two(analog_input_two)
   );

   task automatic summarize();
      $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // The request stands until the edge that sees waitrequest low.
   task automatic bus(input logic wr, input logic [5:0] idx,
                      input logic [31:0] d);
      int i;
      @(posedge clock);
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clock);
         if (avs_waitrequest === 1'b0)
            break;
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (i == 20)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, 1, 0);
         summarize();
      end
   endtask

   task automatic w(input logic [5:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0000_0000);
      chk(rd, exp);
   endtask

   task automatic pins(input logic [15:0] a, input logic [15:0] b,
                       input logic [15:0] m);
      @(posedge clock);
      one_set <= a;
      two_set <= b;
      main_freq_cmd <= m;
   endtask

   // Outputs follow a sample tick; a few extra edges cover the pin sync.
   task automatic ticks(input int n);
      repeat (n * SC + 6) @(posedge clock);
   endtask

   // A one-tick pulse is caught by watching freq_ref on every edge.
   task automatic span(input int n, output logic [15:0] lo,
                       output logic [15:0] hi);
      lo = 16'hffff;
      hi = 16'h0000;
      repeat (n)
      begin
         @(posedge clock);
         if (freq_ref < lo)
            lo = freq_ref;
         if (freq_ref > hi)
            hi = freq_ref;
      end
   endtask

   task automatic t_regs();
      rchk(REG_CTRL, 32'h0000_2101);
      rchk(REG_FBGAIN, 32'h0000_0064);
      rchk(REG_ILIM, 32'h0000_03e8);
      rchk(6'h20, 32'h0000_0000);
      w(REG_OUT, 32'h0000_1234);
      rchk(REG_OUT, 32'h0000_0000);
   endtask

   task automatic t_bypass();
      pins(16'h1388, 16'h0fa0, 16'h0bb8);
      w(REG_CTRL, 32'h0000_2100);
      ticks(3);
      chk(freq_ref, 16'h0bb8);
   endtask

   task automatic t_prop();
      w(REG_KP, 32'h0000_00c8);
      w(REG_TI, 32'h0000_0000);
      w(REG_FBGAIN, 32'h0000_0032);
      pins(16'h1388, 16'h0fa0, 16'h03e8);
      w(REG_CTRL, 32'h0000_2101);
      ticks(3);
      chk(freq_ref, 16'h1770);
      chk(reverse_dir, 1'b0);
      rchk(REG_OUT, 32'h0000_1770);
   endtask

   task automatic t_polarity();
      w(REG_CTRL, 32'h0000_2103);
      ticks(3);
      chk(freq_ref, 16'h0000);
      chk(reverse_dir, 1'b0);
      w(REG_CTRL, 32'h0000_2113);
      ticks(3);
      chk(freq_ref, 16'h1770);
      chk(reverse_dir, 1'b1);
   endtask

   task automatic t_limits();
      w(REG_CTRL, 32'h0000_2101);
      w(REG_OLIM, 32'h0000_09c4);
      ticks(3);
      chk(freq_ref, 16'h09c4);
      w(REG_OLIM, 32'h0000_2710);
      w(REG_BIAS, 32'h0000_000a);
      w(REG_OGAIN, 32'h0000_0014);
      ticks(3);
      chk(freq_ref, 16'h36b0);
      w(REG_BIAS, 32'h0000_0000);
      w(REG_OGAIN, 32'h0000_000a);
      w(REG_CTRL, 32'h0000_2109);
      ticks(3);
      chk(freq_ref, 16'h1b58);
   endtask

   task automatic t_errors();
      w(REG_CTRL, 32'h0000_1101);
      repeat (3) @(posedge clock);
      chk(regulator_setting_error, 1'b1);
      w(REG_CTRL, 32'h0000_4401);
      repeat (3) @(posedge clock);
      chk(regulator_setting_error, 1'b0);
      w(REG_DISP, 32'h03e8_0010);
      repeat (3) @(posedge clock);
      chk(regulator_setting_error, 1'b1);
      w(REG_DISP, 32'h03e7_0010);
      repeat (3) @(posedge clock);
      chk(regulator_setting_error, 1'b0);
      w(REG_DISP, 32'h03e7_0000);
      repeat (3) @(posedge clock);
      chk(regulator_setting_error, 1'b1);
      w(REG_DISP, 32'h0000_0001);
   endtask

   task automatic t_sources();
      logic [15:0] exp [4];
      logic [2:0] code [4];
      exp = '{16'h1388, 16'h07d0, 16'h1770, 16'h0bb8};
      code = '{SRC_KEYPAD, SRC_AI1, SRC_AI2, SRC_SETPT};
      w(REG_KP, 32'h0000_0064);
      w(REG_KEYPAD, 32'h0000_1388);
      w(REG_SETPT, 32'h0000_012c);
      pins(16'h07d0, 16'h1770, 16'h0000);
      for (int k = 0; k < 4; k++)
      begin
         w(REG_CTRL, 32'h0000_4001 | (32'(code[k]) << CTRL_TSRC));
         ticks(3);
         chk(freq_ref, exp[k]);
      end
      rchk(REG_FB, 32'h0000_0000);
   endtask

   task automatic t_integral();
      w(REG_KP, 32'h0000_0000);
      w(REG_ILIM, 32'h0000_000a);
      w(REG_TI, 32'h0000_0001);
      pins(16'h1388, 16'h0000, 16'h0000);
      w(REG_CTRL, 32'h0000_2100);
      w(REG_CTRL, 32'h0000_2101);
      ticks(6);
      chk(freq_ref, 16'h0064);
      w(REG_TI, 32'h0000_0000);
      w(REG_ILIM, 32'h0000_03e8);
      w(REG_KP, 32'h0000_0064);
   endtask

   task automatic t_ramp();
      w(REG_RAMP, 32'h0000_0001);
      @(posedge clock);
      run <= 1'b0;
      ticks(1);
      run <= 1'b1;
      ticks(3);
      comparisons++;
      // Mid-ramp the target is still well short of the setpoint.
      if ((freq_ref > 16'h0000 && freq_ref < 16'h03e8) !== 1'b1)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time,
                  freq_ref, 16'h0190);
      end
      soft_setpoint_ramp_off <= 1'b1;
      ticks(2);
      chk(freq_ref, 16'h1388);
   endtask

   task automatic t_dyn();
      logic [15:0] lo, hi;
      w(REG_TD, 32'h0000_0001);
      ticks(3);
      pins(16'h13ec, 16'h0000, 16'h0000);
      span(4 * SC, lo, hi);
      chk(hi, 16'h17d4);
      chk(freq_ref, 16'h13ec);
      w(REG_CTRL, 32'h0000_2105);
      ticks(3);
      pins(16'h1388, 16'h0000, 16'h0000);
      span(4 * SC, lo, hi);
      chk(lo, 16'h1388);
      chk(freq_ref, 16'h1388);
      w(REG_TD, 32'h0000_0000);
      w(REG_FILT, 32'h0000_0001);
      w(REG_CTRL, 32'h0000_2100);
      ticks(1);
      chk(freq_ref, 16'h0000);
      w(REG_CTRL, 32'h0000_2101);
      span(SC + 1, lo, hi);
      chk(hi, 16'h01c6);
   endtask

   task automatic t_reset();
      @(posedge clock);
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      chk(freq_ref, 16'h0000);
      chk(avs_waitrequest, 1'b1);
      arst_n <= 1'b1;
      repeat (6) @(posedge clock);
      rchk(REG_FILT, 32'h0000_0000);
   endtask

   initial
   begin
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      run <= 1'b1;
      repeat (6) @(posedge clock);
      t_regs();
      t_bypass();
      t_prop();
      t_polarity();
      t_limits();
      t_errors();
      t_sources();
      t_integral();
      t_ramp();
      t_dyn();
      t_reset();
      summarize();
   end
endmodule
